//--- hdl/axr_ram.sv
// auxiliary data ram mapped into the external data space, with page register
// assumes the core drives requests on ref_clk; flash redirection decided here
//
// Functional notes
// - 512 byte ram in external data space
// - every byte reachable by wide or narrow moves
// - narrow move: high byte from page register
// - reads always hit ram; writes hit ram unless flash writing enabled
// - wide moves ignore upper seven address bits
// - page register bits 7..1 read zero
// - page bit zero selects 256 byte page
// - page register resets to zero
`timescale 1ns/1ns
module axr_ram #(
    parameter int DEPTH = axr_pkg::RAM_BYTES
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire axr_pkg::axr_req_t req,
    input wire logic flash_write_en,
    input wire axr_pkg::axr_sfr_t sfr,
    output logic [7:0] rdata,
    output logic rvalid,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    output logic flash_req
);
    localparam int IW = axr_pkg::IDX_W;

    // page register state
    logic page_select_bit_r;
    logic page_select_bit_nxt;

    // register decode
    logic page_wr;
    logic page_rd;

    // register read-back
    logic [7:0] sfr_rdata_r;
    logic [7:0] sfr_rdata_nxt;

    // address mapping
    logic [IW-1:0] wide_idx;
    logic [IW-1:0] narrow_idx;
    logic [IW-1:0] idx;

    // move steering
    logic ram_sel;
    logic ram_wr;
    logic ram_rd;
    logic flash_sel;

    // storage, one byte cell per entry
    logic [7:0] cell_bus [DEPTH];

    // read path
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic rvalid_r;
    logic rvalid_nxt;

    // only the page register lives here; other addresses are ignored
    always_comb begin
        page_wr = 1'b0;
        page_rd = 1'b0;
        if (sfr.addr == axr_pkg::PAGE_REG_ADDR) begin
            page_wr = sfr.wr;
            page_rd = sfr.rd;
        end else begin
            page_wr = 1'b0;
            page_rd = 1'b0;
        end
    end

    assign sfr_hit = page_wr || page_rd;

    always_comb begin
        page_select_bit_nxt = page_select_bit_r;
        if (page_wr) begin
            // upper bits are not stored, so writes there vanish
            page_select_bit_nxt = sfr.wdata[axr_pkg::PAGE_BIT_POS];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            page_select_bit_r <= axr_pkg::PAGE_REG_RESET[0];
        end else begin
            page_select_bit_r <= page_select_bit_nxt;
        end
    end

    // a read in the cycle of a write returns the old page value
    always_comb begin
        sfr_rdata_nxt = sfr_rdata_r;
        if (page_rd) begin
            sfr_rdata_nxt = {7'h00, page_select_bit_r};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            sfr_rdata_r <= axr_pkg::PAGE_REG_RESET;
        end else begin
            sfr_rdata_r <= sfr_rdata_nxt;
        end
    end

    assign sfr_rdata = sfr_rdata_r;

    // wide moves drop addr[15:9], giving the 512 byte alias
    always_comb begin
        wide_idx = {req.addr[axr_pkg::ADDR_BIT8_POS], req.addr[7:0]};
    end

    // narrow moves take the high byte from the page register
    always_comb begin
        narrow_idx = {page_select_bit_r, req.addr[7:0]};
    end

    always_comb begin
        if (req.wide) begin
            idx = wide_idx;
        end else begin
            idx = narrow_idx;
        end
    end

    // flash writes steal only writes; reads still come from ram
    always_comb begin
        flash_sel = req.valid && req.write && flash_write_en;
        ram_sel = req.valid && !flash_sel;
        ram_wr = ram_sel && req.write;
        ram_rd = ram_sel && !req.write;
    end

    assign flash_req = flash_sel;

    // one cell per entry; contents carry no reset, as in a real sram
    genvar k;
    generate
        for (k = 0; k < DEPTH; k++) begin : g_cell
            localparam logic [IW-1:0] ENTRY = IW'(k);
            logic [7:0] cell_r;
            logic [7:0] cell_nxt;

            always_comb begin
                cell_nxt = cell_r;
                if (ram_wr && idx == ENTRY) begin
                    cell_nxt = req.wdata;
                end
            end

            always_ff @(posedge ref_clk) begin
                cell_r <= cell_nxt;
            end

            assign cell_bus[k] = cell_r;
        end
    endgenerate

    // a write followed by a read of the same byte sees the new data
    always_comb begin
        rvalid_nxt = ram_rd;
        rdata_nxt = rdata_r;
        if (ram_rd) begin
            rdata_nxt = cell_bus[idx];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            rdata_r <= 8'h00;
            rvalid_r <= 1'b0;
        end else begin
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    assign rdata = rdata_r;
    assign rvalid = rvalid_r;

    // note: rdata holds its last value between reads, so a consumer must
    // qualify it with rvalid; holding costs nothing and avoids glitches
endmodule : axr_ram

//--- hdl/axr_pkg.sv
// package for the auxiliary data ram block: offsets, reset values, carriers
// assumes a single 25 MHz system clock and one core-side access port
package axr_pkg;
    localparam int RAM_BYTES = 512;
    localparam int IDX_W = 9;
    localparam logic [7:0] PAGE_REG_ADDR = 8'hAA;
    localparam logic [7:0] PAGE_REG_RESET = 8'h00;
    localparam int PAGE_BIT_POS = 0;
    localparam int ADDR_BIT8_POS = 8;
    localparam real CLK_MHZ = 25.0;

    // one external data move request from the core
    typedef struct packed {
        logic valid;
        logic write;
        logic wide;
        logic [15:0] addr;
        logic [7:0] wdata;
    } axr_req_t;

    // special function register access from the core
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } axr_sfr_t;
endpackage : axr_pkg

//--- test/axr_ram_checker.sv
// port assertions for the auxiliary ram
// assumes the bind in the bench top file
`timescale 1ns/1ns
module axr_ram_checker(
input wire logic ref_clk,
input wire logic resetn,
input wire axr_pkg::axr_req_t req,
input wire logic flash_write_en,
input wire axr_pkg::axr_sfr_t sfr,
input wire logic [7:0] rdata,
input wire logic rvalid,
input wire logic [7:0] sfr_rdata,
input wire logic sfr_hit,
input wire logic flash_req);
default clocking @(posedge ref_clk); endclocking
default disable iff (!resetn);
a_read_ans: assert property(req.valid&&!req.write|=>rvalid)
 else $error("rv");
a_no_spur: assert property(!(req.valid&&!req.write)|=>!rvalid)
 else $error("sp");
a_flash_red: assert property(flash_req==(req.valid&&req.write&&flash_write_en))
 else $error("fl");
a_sfr_hit: assert property(sfr_hit==((sfr.rd||sfr.wr)&&sfr.addr==8'hAA))
 else $error("hit");
a_page_hi: assert property(sfr_rdata[7:1]==7'h00) else $error("hi");
a_page_rd: assert property(sfr_hit&&sfr.wr##1 sfr_hit&&!sfr.wr|=>
 sfr_rdata[0]==$past(sfr.wdata[0],2)) else $error("pg");
a_rst_zero: assert property($rose(resetn)|->sfr_rdata==8'h00&&!rvalid)
 else $error("rst");
a_sfr_hold: assert property(!(sfr_hit&&sfr.rd)|=>$stable(sfr_rdata))
 else $error("hold");
cover property(rvalid);
cover property(flash_req);
cover property(sfr_hit&&sfr.wr);
endmodule : axr_ram_checker

//--- test/axr_core_model.sv
// core model: one external data move per call, one cycle wide
// assumes the bench calls mv and that the ram answers one cycle later
`timescale 1ns/1ns
module axr_core_model(input wire logic ref_clk,output axr_pkg::axr_req_t req);
initial req = '0;
task automatic mv(input logic w, wd, input logic [15:0] a, logic [7:0] d);
    @(posedge ref_clk) req <= '{1'b1, w, wd, a, d};
    @(posedge ref_clk) req <= '0;
endtask : mv
endmodule : axr_core_model

//--- test/axr_ram_test.sv
// bench top: random moves, page register, flash redirect
// assumes the core model drives req
`timescale 1ns/1ns
`define CHK(n,e,s) begin checks++; if ((s)!==(e)) begin error_cnt++; \
 $display("BAD %s exp %h got %h", n, e, s); end end
module axr_ram_test;
logic ref_clk = 0, resetn = 0, fwe = 0, p = 0, w, wd;
axr_pkg::axr_sfr_t sfr = '0;
axr_pkg::axr_req_t req;
logic [7:0] rdata, sfr_rdata, d, m[512];
logic rvalid, hit, frq;
logic [15:0] a;
int error_cnt = 0, checks = 0;
initial forever #20 ref_clk = ~ref_clk;
axr_core_model core(.ref_clk(ref_clk), .req(req));
axr_ram dut(.ref_clk(ref_clk), .resetn(resetn), .req(req), .sfr(sfr),
 .flash_write_en(fwe), .rdata(rdata), .rvalid(rvalid),
 .sfr_rdata(sfr_rdata), .sfr_hit(hit), .flash_req(frq));
function automatic logic [8:0] ix(logic wd, logic [15:0] a);
    return wd ? a[8:0] : {p, a[7:0]};
endfunction : ix
// mid-cycle look at the combinational flash steering
always @(negedge ref_clk) if (req.valid) `CHK("flash", req.write && fwe, frq)
task automatic pg(input logic [7:0] v);
    @(posedge ref_clk) sfr <= '{1'b0, 1'b1, 8'hAA, v};
    #1 `CHK("hit", 1'b1, hit)
    @(posedge ref_clk) sfr <= '{1'b1, 1'b0, 8'hAA, 8'h00};
    @(posedge ref_clk) sfr <= '0;
    p = v[0];
    #1 `CHK("page", {7'h00, v[0]}, sfr_rdata)
endtask : pg
task test_done;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
endtask : test_done
initial begin
    void'($urandom(24));
    repeat (3) @(posedge ref_clk);
    resetn <= 1;
    #1 `CHK("rst", 8'h00, sfr_rdata)
    for (int i = 0; i < 900; i++) begin
        a = 16'($urandom);
        d = 8'($urandom);
        {w, wd} = 2'($urandom);
        // fill every byte first through random upper address bits
        if (i < 512) begin a[8:0] = 9'(i); {w, wd} = 2'b11; end
        if (i % 64 == 0) pg(8'($urandom));
        fwe <= i > 800;
        core.mv(w, wd, a, d);
        if (w && !fwe) m[ix(wd, a)] = d;
        #1 `CHK("rv", !w, rvalid)
        if (!w) `CHK("rd", m[ix(wd, a)], rdata)
    end
    test_done();
end
endmodule : axr_ram_test
bind axr_ram axr_ram_checker chk(.*);
